// ### test/swc_pin_model.sv
// swc_pin_model: outside pins that act as wake sources for the stop recovery block
`timescale 1ns/1ns
`default_nettype none
module swc_pin_model
  import swc_pkg::*;
#(
  parameter int HOLD = 8
)
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [2:0] src,
  input  wire logic       pol,
  input  wire logic [7:0] dir,
  input  wire logic       wake_req,
  output logic      [3:1] port3_in,
  output logic      [7:0] port2_in
);
  logic [3:0] hold_q;
  logic       tog_q;
  logic       act;
  logic [7:0] grp;

  // ==========================================================================
  // hold counter: once asked, the source stays active for a fixed count
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold_q <= 4'h0;
      tog_q  <= 1'b0;
    end else begin
      tog_q <= ~tog_q;
      if (wake_req && hold_q == 4'h0) begin
        hold_q <= 4'(HOLD);
      end else if (hold_q != 4'h0) begin
        hold_q <= hold_q - 4'h1;
      end
    end
  end

  assign act = (hold_q != 4'h0);
  assign grp = (src == SWC_SRC_NOR4) ? 8'h0f : 8'hff;

  // ==========================================================================
  // pin levels: unselected pins toggle every cycle, port2 outputs inside the nor group sit high in the nor modes
  always_comb begin
    port3_in = {3{tog_q}};
    port2_in = {8{tog_q}};
    case (src)
      SWC_SRC_PORT3_BIT1: port3_in[1] = act ? pol : ~pol;
      SWC_SRC_PORT3_BIT2: port3_in[2] = act ? pol : ~pol;
      SWC_SRC_PORT3_BIT3: port3_in[3] = act ? pol : ~pol;
      SWC_SRC_PORT2_BIT7: port2_in[7] = act ? pol : ~pol;
      SWC_SRC_NOR4, SWC_SRC_NOR8: begin
        port2_in = (port2_in & ~grp) | (grp & ~dir);
        if (pol && !act) port2_in[1] = 1'b1;
        if (!pol && act) port2_in[3] = 1'b1;
      end
      default: ;
    endcase
  end
endmodule
`default_nettype wire

// ### test/testbench.sv
// testbench: self-checking bench for the stop recovery and port configuration block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import swc_pkg::*;
  localparam int TPOR = 8;
  logic        clk_sys      = 1'b0;
  logic        rst          = 1'b1;
  logic        ext_reset_n  = 1'b1;
  logic [11:0] paddr        = 12'h000;
  logic        psel         = 1'b0;
  logic        penable      = 1'b0;
  logic        pwrite       = 1'b0;
  logic [31:0] pwdata       = 32'h0;
  logic [1:0]  cmp_out      = 2'h0;
  logic [7:0]  port2_dir_in = 8'hff;
  logic [2:0]  m_src        = 3'h0;
  logic        m_pol        = 1'b0;
  logic        wake_req     = 1'b0;
  logic [31:0] prdata, rd;
  logic [3:1]  port3_in;
  logic [7:0]  port2_in, v;
  logic        pready, pslverr, port3_cmp_en, port3_bit4, port3_bit7, er;
  logic        port1_push_pull, port0_push_pull, clk_div16, core_clk_run, core_reset, irq;
  int          err_count = 0;
  int          comparisons = 0;
  int          seed = 99;
  int          cyc = 0;
  int          rs;

  swc_top #(.TPOR_CYC(TPOR)) swc_top_inst (.clk_sys(clk_sys), .rst(rst), .ext_reset_n(ext_reset_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp_out(cmp_out), .port3_in(port3_in), .port2_in(port2_in),
    .port2_dir_in(port2_dir_in), .port3_cmp_en(port3_cmp_en), .port3_bit4(port3_bit4),
    .port3_bit7(port3_bit7), .port1_push_pull(port1_push_pull), .port0_push_pull(port0_push_pull),
    .clk_div16(clk_div16), .core_clk_run(core_clk_run), .core_reset(core_reset), .irq(irq));
  swc_pin_model swc_pin_model_inst (.clk_sys(clk_sys), .rst(rst), .src(m_src), .pol(m_pol),
    .dir(port2_dir_in), .wake_req(wake_req), .port3_in(port3_in), .port2_in(port2_in));

  // ==========================================================================
  // clock and run limit
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      summarize();
    end
  end

  // ==========================================================================
  // compare, verdict, bus cycles and expectations
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    psel   <= 1'b1;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1);
    chk(32'(n), 32'h1, "access cycles");
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(a, 1'b1, {24'h0, d});
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string what);
    apb(a, 1'b0, 32'h0);
    chk(rd & m, e, what);
    chk(32'(er), 32'h0, "slave error");
  endtask
  task automatic wait_run();
    rs = 0;
    while (core_clk_run !== 1'b1) begin
      @(posedge clk_sys);
      if (core_reset === 1'b1) rs++;
    end
  endtask
  function automatic logic [31:0] exp_pcfg(input logic [7:0] x);
    return {29'h0, x[SWC_PC_P0_PP], x[SWC_PC_P1_PP], x[SWC_PC_CMP_OUT]};
  endfunction
  function automatic logic [31:0] delay_ok(input logic d, input int n);
    return d ? 32'(n >= TPOR && n <= TPOR + 1) : 32'(n == 0);
  endfunction
  task automatic stop_wake(input logic [2:0] s, input logic p, input logic d);
    logic dv;
    dv = 1'($random(seed));
    m_src <= s;
    m_pol <= p;
    port2_dir_in <= 8'($random(seed)) | 8'h0a;
    wr(SWC_OFF_STOP_CTL, {1'b0, p, d, s, 1'b0, dv});
    wr(SWC_OFF_CORE_CMD, SWC_OP_NOP);
    chk(32'(clk_div16), 32'(dv), "divide by sixteen");
    wr(SWC_OFF_CORE_CMD, SWC_OP_STOP);
    rdc(SWC_OFF_STATE, 32'h3, 32'h2, "stop entered");
    chk(32'(core_clk_run), 32'h0, "clock stopped");
    wake_req <= 1'b1;
    @(posedge clk_sys);
    wake_req <= 1'b0;
    wait_run();
    chk(delay_ok(d, rs), 32'h1, "recovery delay");
    rdc(SWC_OFF_STOP_CTL, 32'hffffffff, 32'h80, "warm flag");
    rdc(SWC_OFF_STATE, 32'h3, 32'h0, "running");
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rdc(SWC_OFF_STOP_CTL, 32'hffffffff, 32'h0, "cold start");
    wr(SWC_OFF_STOP_CTL, 8'ha0); // delay bit kept set
    rdc(SWC_OFF_STOP_CTL, 32'hffffffff, 32'h0, "flag not writable");
    apb(12'h020, 1'b0, 32'h0);
    chk(32'(er), 32'h1, "unmapped error");
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'hff : 8'($random(seed));
      cmp_out <= 2'($random(seed));
      wr(SWC_OFF_PORT_CFG, v);
      @(posedge clk_sys);
      chk({port0_push_pull, port1_push_pull, port3_cmp_en}, exp_pcfg(v), "port modes");
      if (v[0]) chk({port3_bit7, port3_bit4}, cmp_out, "comparator pins");
      rdc(SWC_OFF_PORT_CFG, 32'hffffffff, 32'h0, "write only");
    end
    $display("registers test done");
    wr(SWC_OFF_IRQ_MASK, 8'h01);
    for (int s = 2; s < 8; s++) begin
      for (int p = 0; p < 2; p++) begin
        stop_wake(3'(s), 1'(p), (s == 2) ? 1'(p) : 1'($random(seed)));
      end
    end
    chk(32'(irq), 32'h1, "wake interrupt");
    rdc(SWC_OFF_IRQ_STAT, 32'h7, 32'h3, "status bits");
    wr(SWC_OFF_IRQ_STAT, 8'h07);
    chk(32'(irq), 32'h0, "interrupt cleared");
    $display("wake sources test done");
    wr(SWC_OFF_CORE_CMD, SWC_OP_NOP);
    wr(SWC_OFF_CORE_CMD, SWC_OP_HALT);
    rdc(SWC_OFF_STATE, 32'h3, 32'h1, "halt entered");
    chk(32'(irq), 32'h0, "halt masked");
    wr(SWC_OFF_IRQ_MASK, 8'h04);
    chk(32'(irq), 32'h1, "halt interrupt");
    wake_req <= 1'b1;
    @(posedge clk_sys);
    wake_req <= 1'b0;
    wait_run();
    rdc(SWC_OFF_STATE, 32'h3, 32'h0, "halt left");
    wr(SWC_OFF_IRQ_STAT, 8'h07);
    $display("halt test done");
    ext_reset_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    ext_reset_n <= 1'b1;
    wait_run();
    rdc(SWC_OFF_STOP_CTL, 32'h80, 32'h0, "warm cleared");
    m_src <= SWC_SRC_RSVD;
    wr(SWC_OFF_STOP_CTL, 8'h04); // reserved source never wakes
    wr(SWC_OFF_CORE_CMD, SWC_OP_NOP);
    wr(SWC_OFF_CORE_CMD, SWC_OP_STOP);
    ext_reset_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    ext_reset_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rdc(SWC_OFF_STATE, 32'h3, 32'h2, "still stopped");
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rdc(SWC_OFF_STATE, 32'h3, 32'h0, "reset leaves stop");
    $display("external reset test done");
    summarize();
  end
endmodule
`default_nettype wire

// ### verilog/swc_pkg.sv
// swc_pkg: shared constants and types for the stop recovery and port configuration block
package swc_pkg;

  // ==========================================================================
  // register map (byte addresses on the apb bus)
  localparam int          SWC_WORD_SHIFT     = 2;       // one aligned word per register index
  localparam logic [11:0] SWC_IDX_PORT_CFG   = 12'h000; // port_output_config index, write only
  localparam logic [11:0] SWC_IDX_STOP_CTL   = 12'h00b; // stop_wake_control index
  localparam logic [11:0] SWC_OFF_PORT_CFG   = SWC_IDX_PORT_CFG << SWC_WORD_SHIFT;
  localparam logic [11:0] SWC_OFF_STOP_CTL   = SWC_IDX_STOP_CTL << SWC_WORD_SHIFT;
  localparam logic [11:0] SWC_OFF_IRQ_STAT   = 12'h010;
  localparam logic [11:0] SWC_OFF_IRQ_MASK   = 12'h014;
  localparam logic [11:0] SWC_OFF_CORE_CMD   = 12'h018;
  localparam logic [11:0] SWC_OFF_STATE      = 12'h01c;

  // ==========================================================================
  // port_output_config fields
  localparam int SWC_PC_CMP_OUT  = 0;
  localparam int SWC_PC_P1_PP    = 1;
  localparam int SWC_PC_P0_PP    = 2;
  localparam logic [7:0] SWC_PC_RESET = 8'h00;

  // ==========================================================================
  // stop_wake_control fields
  localparam int SWC_SC_DIV16    = 0;
  localparam int SWC_SC_SRC_LO   = 2;
  localparam int SWC_SC_SRC_HI   = 4;
  localparam int SWC_SC_DELAY    = 5;
  localparam int SWC_SC_POL      = 6;
  localparam int SWC_SC_WARM     = 7;
  localparam logic [6:0] SWC_SC_RESET = 7'h20; // delay enabled, low level wake

  // wake source encodings
  localparam logic [2:0] SWC_SRC_NONE   = 3'h0;
  localparam logic [2:0] SWC_SRC_RSVD   = 3'h1;
  localparam logic [2:0] SWC_SRC_PORT3_BIT1 = 3'h2;
  localparam logic [2:0] SWC_SRC_PORT3_BIT2 = 3'h3;
  localparam logic [2:0] SWC_SRC_PORT3_BIT3 = 3'h4;
  localparam logic [2:0] SWC_SRC_PORT2_BIT7 = 3'h5;
  localparam logic [2:0] SWC_SRC_NOR4   = 3'h6;
  localparam logic [2:0] SWC_SRC_NOR8   = 3'h7;

  // core opcodes
  localparam logic [7:0] SWC_OP_NOP  = 8'hff;
  localparam logic [7:0] SWC_OP_STOP = 8'h6f;
  localparam logic [7:0] SWC_OP_HALT = 8'h7f;

  // ==========================================================================
  // timing: power-on delay and fast wake hold time
  localparam int SWC_CLK_NS        = 100;
  localparam int SWC_TPOR_US       = 100;
  localparam int SWC_TPOR_CYC      = (SWC_TPOR_US * 1000) / SWC_CLK_NS;
  localparam int SWC_FAST_HOLD_CYC = 5;
  localparam int SWC_SYNC_DEPTH    = 3;

  // interrupt bits
  localparam int SWC_IRQ_WAKE = 0;
  localparam int SWC_IRQ_STOP = 1;
  localparam int SWC_IRQ_HALT = 2;
  localparam int SWC_IRQ_W    = 3;

  typedef enum logic [1:0] {
    SWC_ST_RUN,
    SWC_ST_HALT,
    SWC_ST_STOP,
    SWC_ST_DELAY
  } swc_state_t;

endpackage

// ### verilog/swc_top.sv
// swc_top: stop mode recovery control and port output configuration with apb access
//
// The APB slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module swc_top
  import swc_pkg::*;
#(
  parameter int TPOR_CYC = SWC_TPOR_CYC
)
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        ext_reset_n,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  cmp_out,
  input  wire logic [3:1]  port3_in,
  input  wire logic [7:0]  port2_in,
  input  wire logic [7:0]  port2_dir_in,
  output logic             port3_cmp_en,
  output logic             port3_bit4,
  output logic             port3_bit7,
  output logic             port1_push_pull,
  output logic             port0_push_pull,
  output logic             clk_div16,
  output logic             core_clk_run,
  output logic             core_reset,
  output logic             irq
);

  // ==========================================================================
  // apb decode
  logic        acc, wr;
  logic [11:0] a;
  assign acc = psel & penable;
  assign wr  = acc & pwrite;
  assign a   = paddr;

  function automatic logic hit(input logic [11:0] ad, input logic [11:0] off);
    hit = (ad == off);
  endfunction

  // ==========================================================================
  // register state
  logic [7:0]        pcfg_q, pcfg_d;
  logic [6:0]        sctl_q, sctl_d;
  logic              warm_q, warm_d;
  logic [SWC_IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d;
  logic [7:0]        op_q, op_d, prev_op_q, prev_op_d;
  logic              op_ok_q, op_ok_d;
  swc_state_t        st_q, st_d;
  logic [31:0]       cnt_q, cnt_d;
  logic [31:0]       rdat_d;
  logic              rdy_d, err_d;
  logic [1:0]        cmp_q;
  logic [2:0]        ext_s_q;
  logic              ext_lvl_q, ext_lvl_d;
  logic [SWC_IRQ_W-1:0] ev;
  logic              p3_en_d, p1_d, p0_d, div_d, run_d, crst_d, irq_d;
  logic              bit4_d, bit7_d;

  swc_wake_if wif ();
  assign wif.src       = sctl_q[SWC_SC_SRC_HI:SWC_SC_SRC_LO];
  assign wif.pol       = sctl_q[SWC_SC_POL];
  assign wif.p2_dir_in = port2_dir_in;

  swc_wake_det u_det (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .port3_in (port3_in),
    .port2_in (port2_in),
    .wif      (wif)
  );

  // ==========================================================================
  // external reset synchroniser, used as a core reset and as a halt wake, but never as a stop wake
  always_comb begin
    ext_lvl_d = ext_lvl_q;
    if (ext_s_q[1] == ext_s_q[2]) begin
      ext_lvl_d = ~ext_s_q[2];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ext_s_q   <= 3'h7;
      ext_lvl_q <= 1'b0;
    end else begin
      ext_s_q   <= {ext_s_q[1:0], ext_reset_n};
      ext_lvl_q <= ext_lvl_d;
    end
  end

  // ==========================================================================
  // next state: registers, opcode watch, stop sequencer, interrupts
  always_comb begin
    pcfg_d    = pcfg_q;
    sctl_d    = sctl_q;
    warm_d    = warm_q;
    mask_d    = mask_q;
    op_d      = op_q;
    prev_op_d = prev_op_q;
    op_ok_d   = 1'b0;
    st_d      = st_q;
    cnt_d     = cnt_q;
    ev        = '0;
    if (wr && hit(a, SWC_OFF_PORT_CFG)) begin
      pcfg_d = pwdata[7:0];
    end
    if (wr && hit(a, SWC_OFF_STOP_CTL)) begin
      sctl_d = pwdata[6:0]; // top bit ignored on write
    end
    if (wr && hit(a, SWC_OFF_IRQ_MASK)) begin
      mask_d = pwdata[SWC_IRQ_W-1:0];
    end
    if (wr && hit(a, SWC_OFF_CORE_CMD)) begin
      prev_op_d = op_q;
      op_d      = pwdata[7:0];
      op_ok_d   = 1'b1;
    end
    if (ext_lvl_q && st_q != SWC_ST_STOP) begin
      warm_d = 1'b0; // external reset is a cold reset
    end
    case (st_q)
      SWC_ST_RUN: begin
        if (op_ok_q && prev_op_q == SWC_OP_NOP && op_q == SWC_OP_STOP) begin
          st_d = SWC_ST_STOP;
          ev[SWC_IRQ_STOP] = 1'b1;
        end else if (op_ok_q && prev_op_q == SWC_OP_NOP && op_q == SWC_OP_HALT) begin
          st_d = SWC_ST_HALT;
          ev[SWC_IRQ_HALT] = 1'b1;
        end
      end
      SWC_ST_HALT: begin
        if (ext_lvl_q || wif.wake) begin
          st_d = SWC_ST_RUN;
        end
      end
      SWC_ST_STOP: begin
        // external reset is ignored here
        if (wif.wake) begin
          warm_d = 1'b1;
          ev[SWC_IRQ_WAKE] = 1'b1;
          cnt_d = '0;
          st_d = sctl_q[SWC_SC_DELAY] ? SWC_ST_DELAY : SWC_ST_RUN;
        end
      end
      SWC_ST_DELAY: begin
        cnt_d = cnt_q + 32'h1;
        if (cnt_q >= 32'(TPOR_CYC - 1)) begin
          st_d = SWC_ST_RUN;
        end
      end
      default: st_d = SWC_ST_RUN;
    endcase
    // set wins over write-one-to-clear
    stat_d = stat_q;
    if (wr && hit(a, SWC_OFF_IRQ_STAT)) begin
      stat_d = stat_q & ~pwdata[SWC_IRQ_W-1:0];
    end
    stat_d = stat_d | ev;
  end

  // output and bus answer next values
  always_comb begin
    p3_en_d = pcfg_d[SWC_PC_CMP_OUT];
    bit4_d  = cmp_q[0];
    bit7_d  = cmp_q[1];
    p1_d    = pcfg_d[SWC_PC_P1_PP];
    p0_d    = pcfg_d[SWC_PC_P0_PP];
    div_d   = sctl_d[SWC_SC_DIV16];
    run_d   = (st_d == SWC_ST_RUN);
    crst_d  = (st_d == SWC_ST_DELAY) || ext_lvl_q;
    irq_d   = |(stat_d & mask_d);
    rdy_d   = psel & ~penable;
    err_d   = 1'b0;
    rdat_d  = '0;
    if (psel && !penable) begin
      if (hit(a, SWC_OFF_STOP_CTL)) begin
        rdat_d = {24'h0, warm_q, 7'h00};
      end else if (hit(a, SWC_OFF_IRQ_STAT)) begin
        rdat_d = {29'h0, stat_q};
      end else if (hit(a, SWC_OFF_IRQ_MASK)) begin
        rdat_d = {29'h0, mask_q};
      end else if (hit(a, SWC_OFF_STATE)) begin
        rdat_d = {30'h0, st_q};
      end else if (!hit(a, SWC_OFF_PORT_CFG) && !hit(a, SWC_OFF_CORE_CMD)) begin
        err_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pcfg_q          <= SWC_PC_RESET;
      sctl_q          <= SWC_SC_RESET;
      warm_q          <= 1'b0;
      stat_q          <= '0;
      mask_q          <= '0;
      op_q            <= 8'h00;
      prev_op_q       <= 8'h00;
      op_ok_q         <= 1'b0;
      st_q            <= SWC_ST_RUN;
      cnt_q           <= '0;
      cmp_q           <= 2'h0;
      prdata          <= '0;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
      port3_cmp_en    <= 1'b0;
      port3_bit4      <= 1'b0;
      port3_bit7      <= 1'b0;
      port1_push_pull <= 1'b0;
      port0_push_pull <= 1'b0;
      clk_div16       <= 1'b0;
      core_clk_run    <= 1'b1;
      core_reset      <= 1'b0;
      irq             <= 1'b0;
    end else begin
      pcfg_q          <= pcfg_d;
      sctl_q          <= sctl_d;
      warm_q          <= warm_d;
      stat_q          <= stat_d;
      mask_q          <= mask_d;
      op_q            <= op_d;
      prev_op_q       <= prev_op_d;
      op_ok_q         <= op_ok_d;
      st_q            <= st_d;
      cnt_q           <= cnt_d;
      cmp_q           <= cmp_out;
      prdata          <= rdat_d;
      pready          <= rdy_d;
      pslverr         <= err_d;
      port3_cmp_en    <= p3_en_d;
      port3_bit4      <= bit4_d;
      port3_bit7      <= bit7_d;
      port1_push_pull <= p1_d;
      port0_push_pull <= p0_d;
      clk_div16       <= div_d;
      core_clk_run    <= run_d;
      core_reset      <= crst_d;
      irq             <= irq_d;
    end
  end

  // ==========================================================================
  // assertions
  property p_stop_ignores_ext;
    @(posedge clk_sys) disable iff (rst)
      (st_q == SWC_ST_STOP && !wif.wake) |=> (st_q == SWC_ST_STOP);
  endproperty
  a_stop_ignores_ext: assert property (p_stop_ignores_ext) else $error("left stop without wake");

  property p_wake_sets_warm;
    @(posedge clk_sys) disable iff (rst)
      (st_q == SWC_ST_STOP && wif.wake) |=> warm_q;
  endproperty
  a_wake_sets_warm: assert property (p_wake_sets_warm) else $error("warm flag not set");

  property p_fast_wake;
    @(posedge clk_sys) disable iff (rst)
      (st_q == SWC_ST_STOP && wif.wake && !sctl_q[SWC_SC_DELAY]) |=> st_q == SWC_ST_RUN ##1 core_clk_run;
  endproperty
  a_fast_wake: assert property (p_fast_wake) else $error("fast wake not immediate");

  property p_delay_wake;
    @(posedge clk_sys) disable iff (rst)
      (st_q == SWC_ST_STOP && wif.wake && sctl_q[SWC_SC_DELAY]) |=> st_q == SWC_ST_DELAY ##1 core_reset;
  endproperty
  a_delay_wake: assert property (p_delay_wake) else $error("delay not applied");

  property p_cmp_route;
    @(posedge clk_sys) disable iff (rst)
      (wr && hit(a, SWC_OFF_PORT_CFG)) |=> ##1 (port3_cmp_en == $past(pwdata[SWC_PC_CMP_OUT], 2));
  endproperty
  a_cmp_route: assert property (p_cmp_route) else $error("comparator routing wrong");

  property p_p1_mode;
    @(posedge clk_sys) disable iff (rst)
      (wr && hit(a, SWC_OFF_PORT_CFG)) |=> (port1_push_pull == $past(pwdata[SWC_PC_P1_PP]));
  endproperty
  a_p1_mode: assert property (p_p1_mode) else $error("port1 mode wrong");

  property p_p0_mode;
    @(posedge clk_sys) disable iff (rst)
      (wr && hit(a, SWC_OFF_PORT_CFG)) |=> (port0_push_pull == $past(pwdata[SWC_PC_P0_PP]));
  endproperty
  a_p0_mode: assert property (p_p0_mode) else $error("port0 mode wrong");

  property p_cfg_reads_zero;
    @(posedge clk_sys) disable iff (rst)
      (psel && !penable && !pwrite && hit(a, SWC_OFF_PORT_CFG)) |=> (prdata == 32'h0);
  endproperty
  a_cfg_reads_zero: assert property (p_cfg_reads_zero) else $error("config readable");

  property p_warm_read;
    @(posedge clk_sys) disable iff (rst)
      (psel && !penable && hit(a, SWC_OFF_STOP_CTL)) |=> (prdata[6:0] == 7'h0 && prdata[7] == $past(warm_q));
  endproperty
  a_warm_read: assert property (p_warm_read) else $error("stop control read wrong");

  property p_div16;
    @(posedge clk_sys) disable iff (rst)
      (wr && hit(a, SWC_OFF_STOP_CTL)) |=> (clk_div16 == $past(pwdata[SWC_SC_DIV16]));
  endproperty
  a_div16: assert property (p_div16) else $error("divide select wrong");

  property p_nop_stop;
    @(posedge clk_sys) disable iff (rst)
      (st_q == SWC_ST_RUN && op_ok_q && op_q == SWC_OP_STOP && prev_op_q != SWC_OP_NOP) |=> st_q != SWC_ST_STOP;
  endproperty
  a_nop_stop: assert property (p_nop_stop) else $error("stop without nop");

  c_enter_stop: cover property (@(posedge clk_sys) st_q == SWC_ST_RUN ##1 st_q == SWC_ST_STOP);
  c_delay_done: cover property (@(posedge clk_sys) st_q == SWC_ST_DELAY ##1 st_q == SWC_ST_RUN);
  c_halt:       cover property (@(posedge clk_sys) st_q == SWC_ST_HALT);
  c_irq:        cover property (@(posedge clk_sys) irq);

endmodule
`default_nettype wire

// ### verilog/swc_wake_det.sv
// swc_wake_det: synchronises wake pins and picks the qualified wake level
`timescale 1ns/1ns
`default_nettype none
module swc_wake_det
  import swc_pkg::*;
(
  input  wire logic  clk_sys,
  input  wire logic  rst,
  input  wire logic  [3:1] port3_in,
  input  wire logic  [7:0] port2_in,
  swc_wake_if.det    wif
);

  // ==========================================================================
  // three stage synchronisers; a change counts when stages two and three agree
  logic [10:0] raw;
  logic [10:0] s1_q, s2_q, s3_q, f_q;
  logic [10:0] s1_d, s2_d, s3_d, f_d;
  assign raw = {port3_in, port2_in};

  always_comb begin
    s1_d = raw;
    s2_d = s1_q;
    s3_d = s2_q;
    f_d  = f_q;
    for (int i = 0; i < 11; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        f_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_q <= 11'h7ff;
      s2_q <= 11'h7ff;
      s3_q <= 11'h7ff;
      f_q  <= 11'h7ff;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      f_q  <= f_d;
    end
  end

  // ==========================================================================
  // source selection; outputs on port 2 feed an inactive zero into the nor
  logic [7:0] p2_eff;
  logic       sel;
  logic       wake_d, wake_q;

  always_comb begin
    p2_eff = f_q[7:0] & wif.p2_dir_in;
    case (wif.src)
      SWC_SRC_PORT3_BIT1: sel = f_q[8];
      SWC_SRC_PORT3_BIT2: sel = f_q[9];
      SWC_SRC_PORT3_BIT3: sel = f_q[10];
      SWC_SRC_PORT2_BIT7: sel = f_q[7];
      SWC_SRC_NOR4: sel = ~|p2_eff[3:0];
      SWC_SRC_NOR8: sel = ~|p2_eff;
      default:      sel = ~wif.pol; // no pin source: never active
    endcase
    wake_d = ~(sel ^ wif.pol);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= wake_d;
    end
  end

  assign wif.wake = wake_q;

  // ==========================================================================
  // assertions
  property p_src_none_quiet;
    @(posedge clk_sys) disable iff (rst)
      (wif.src == SWC_SRC_NONE) |=> !wake_q;
  endproperty
  a_src_none_quiet: assert property (p_src_none_quiet) else $error("wake with no source");

endmodule
`default_nettype wire

// ### verilog/swc_wake_if.sv
// swc_wake_if: carries the wake selection to the wake detector and its result back
`timescale 1ns/1ns
`default_nettype none
interface swc_wake_if;
  logic [2:0] src;
  logic       pol;
  logic [7:0] p2_dir_in;
  logic       wake;
  modport ctl (output src, output pol, output p2_dir_in, input wake);
  modport det (input src, input pol, input p2_dir_in, output wake);
endinterface
`default_nettype wire
